/* File: timer16_capture.sv */
// 16-bit timer/counter with input capture, classic wishbone slave
// Behaviour
// - the shared high-byte latch keeps its value across many low-byte writes
// - clock select picks internal or external tick; zero stops the counter
// - each tick clears, increments or decrements as the mode requires
// - high-byte location is the latch; low read fills, low write uses it
// - counter is readable and writable with or without a tick
// - a counter write beats a clear or count in the same cycle
// - four-bit mode field is split across control registers a and b
// - overflow flag set where the mode says; it can request an interrupt
// - capture on the selected edge of the pin or comparator result
// - capture copies the counter and sets the capture flag in one cycle
// - capture flag raises a request when enabled; service clears it
// - writing one to the capture flag clears it; zero leaves it
// - read capture low byte first; it loads the latch for the high read
// - capture register takes writes only when it is the mode's top
// - comparator capture select switches trigger to the comparator
// - switching source may capture; software clears the flag afterwards
// - filter output changes only after four equal samples
// - filter samples on the system clock, adding four cycles latency
// - filter and edge detector always run; capture-top modes mask the trigger
// - with the comparator selected, driving the capture pin from its own port does not trigger
// - each capture overwrites the capture register
// - bottom asserts at zero; maximum count is all ones
// - a low-byte write loads latch and low byte together
`timescale 1ns/100ps
module timer16_capture
  import timer16_pkg::*;
(
  input  wire logic        mclk_i,            // system clock, 100 MHz
  input  wire logic        reset_n_i,         // sync reset, active low
  input  wire logic        cyc_i,             // wishbone cycle
  input  wire logic        stb_i,             // wishbone strobe
  input  wire logic        we_i,              // wishbone write enable
  input  wire logic [7:0]  adr_i,             // wishbone byte address
  input  wire logic [3:0]  sel_i,             // wishbone byte selects
  input  wire logic [31:0] dat_i,             // wishbone write data
  output logic      [31:0] dat_o,             // wishbone read data
  output logic             ack_o,             // wishbone acknowledge
  input  wire logic        capture_pin_i,     // capture pin level
  input  wire logic        comparator_result_i, // comparator output
  input  wire logic        external_count_pin_i, // external clock pin
  input  wire logic        overflow_irq_ack_i,  // overflow irq serviced
  input  wire logic        capture_irq_ack_i,   // capture irq serviced
  output logic             overflow_irq_o,    // overflow request
  output logic             capture_irq_o,     // capture request
  output logic             bottom_o           // counter is zero
);
  logic [7:0]    ctrl_a_reg;
  ctrl_b_type    ctrl_b_reg;
  logic [15:0]   counter_value_reg;
  logic [15:0]   counter_value_next;
  logic [15:0]   capture_value_reg;
  logic [7:0]    temp_reg;
  logic [1:0]    flag_reg;
  logic [1:0]    flag_next;
  logic [1:0]    irq_en_reg;
  logic          cmp_sel_reg;
  count_dir_type dir_reg;
  count_dir_type dir_next;
  logic [PRESC_W-1:0] presc_reg;
  logic          ext_prev_reg;
  logic          cap_prev_reg;
  logic          ext_level;
  logic          cap_level;
  logic          cap_src;

  // bus decode: one access per request, acked a cycle later
  logic          req;
  logic          wr;
  logic          rd;
  logic [31:0]   rd_data;
  assign req = cyc_i && stb_i && !ack_o;
  assign wr  = req && we_i && sel_i[0];
  assign rd  = req && !we_i;

  logic wr_ctrl_a;
  logic wr_ctrl_b;
  logic wr_cnt_lo;
  logic wr_cnt_hi;
  logic wr_cap_lo;
  logic wr_cap_hi;
  logic wr_flag;
  logic wr_irq_en;
  logic wr_cmp;
  logic rd_cnt_lo;
  logic rd_cap_lo;
  assign wr_ctrl_a = wr && adr_i == CTRL_A_ADR;
  assign wr_ctrl_b = wr && adr_i == CTRL_B_ADR;
  assign wr_cnt_lo = wr && adr_i == CNT_LO_ADR;
  assign wr_cnt_hi = wr && adr_i == CNT_HI_ADR;
  assign wr_cap_lo = wr && adr_i == CAP_LO_ADR;
  assign wr_cap_hi = wr && adr_i == CAP_HI_ADR;
  assign wr_flag   = wr && adr_i == FLAG_ADR;
  assign wr_irq_en = wr && adr_i == IRQ_EN_ADR;
  assign wr_cmp    = wr && adr_i == CMP_CS_ADR;
  assign rd_cnt_lo = rd && adr_i == CNT_LO_ADR;
  assign rd_cap_lo = rd && adr_i == CAP_LO_ADR;

  // mode field split over both control registers
  logic [3:0]  wgm;
  logic        cap_is_top;
  logic        dual_slope;
  logic [15:0] top;
  assign wgm        = {ctrl_b_reg.wgm_hi, ctrl_a_reg[1:0]};
  assign cap_is_top = wgm == 4'h8 || wgm == 4'hA ||
                      wgm == 4'hC || wgm == 4'hE;
  assign dual_slope = wgm inside {4'h1, 4'h2, 4'h3, 4'h8,
                                  4'h9, 4'hA, 4'hB};
  assign top = (wgm[1:0] == 2'h1 && !wgm[3]) ? TOP_8BIT :
               (wgm[1:0] == 2'h2 && !wgm[3]) ? TOP_9BIT :
               (wgm[1:0] == 2'h3 && !wgm[3]) ? TOP_10BIT :
               cap_is_top ? capture_value_reg : MAX_VAL;

  // tick selection; zero stops every tick, the prescaler still runs
  logic [2:0] cs;
  logic       ext_edge;
  logic       tick;
  assign cs       = ctrl_b_reg.clock_source_select;
  assign ext_edge = (cs == CS_EXT_FALL) ? (ext_prev_reg && !ext_level)
                                        : (!ext_prev_reg && ext_level);
  assign tick = (cs == CS_DIV1) ||
                (cs == CS_DIV8    && &presc_reg[2:0]) ||
                (cs == CS_DIV64   && &presc_reg[5:0]) ||
                (cs == CS_DIV256  && &presc_reg[7:0]) ||
                (cs == CS_DIV1024 && &presc_reg[9:0]) ||
                (cs[2:1] == 2'h3  && ext_edge);

  // count step: clear at top in single slope, else up or down
  logic        at_top;
  logic        at_bottom;
  logic        ovf_event;
  logic [15:0] count_step;
  assign at_top    = counter_value_reg >= top;
  assign at_bottom = counter_value_reg == BOTTOM_VAL;
  assign count_step =
      !dual_slope ? (at_top ? BOTTOM_VAL : counter_value_reg + 16'h0001) :
      (dir_reg == dir_up) ?
        (at_top ? counter_value_reg - 16'h0001
                : counter_value_reg + 16'h0001) :
        (at_bottom ? counter_value_reg + 16'h0001
                   : counter_value_reg - 16'h0001);
  assign dir_next = !dual_slope ? dir_up :
                    (dir_reg == dir_up && at_top) ? dir_down :
                    (dir_reg == dir_down && at_bottom) ? dir_up : dir_reg;
  // overflow: at top in single slope (max in ctc), bottom in dual
  assign ovf_event = tick && (dual_slope ? at_bottom :
                     (wgm == 4'hC ? counter_value_reg == MAX_VAL : at_top));

  // bus write wins over the count
  assign counter_value_next = wr_cnt_lo ? {temp_reg, dat_i[7:0]} :
                              tick ? count_step : counter_value_reg;

  // capture source and edge detector
  logic cap_trig;
  logic edge_hit;
  assign cap_src  = cmp_sel_reg ? comparator_result_i : capture_pin_i;
  assign edge_hit = ctrl_b_reg.edge_rise ? (cap_level && !cap_prev_reg)
                                         : (!cap_level && cap_prev_reg);
  assign cap_trig = edge_hit && !cap_is_top;

  // set wins over software or service clear
  assign flag_next[OVF_BIT] = ovf_event ||
      (flag_reg[OVF_BIT] && !overflow_irq_ack_i &&
       !(wr_flag && dat_i[OVF_BIT]));
  assign flag_next[CAP_BIT] = cap_trig ||
      (flag_reg[CAP_BIT] && !capture_irq_ack_i &&
       !(wr_flag && dat_i[CAP_BIT]));

  // read mux; unmapped addresses read zero
  always_comb begin
    rd_data = 32'h0000_0000;
    case (adr_i)
      CTRL_A_ADR: rd_data[7:0] = ctrl_a_reg;
      CTRL_B_ADR: rd_data[7:0] = ctrl_b_reg;
      CNT_LO_ADR: rd_data[7:0] = counter_value_reg[7:0];
      CNT_HI_ADR: rd_data[7:0] = temp_reg;
      CAP_LO_ADR: rd_data[7:0] = capture_value_reg[7:0];
      CAP_HI_ADR: rd_data[7:0] = temp_reg;
      FLAG_ADR:   rd_data[1:0] = flag_reg;
      IRQ_EN_ADR: rd_data[1:0] = irq_en_reg;
      CMP_CS_ADR: rd_data[1:0] = {comparator_result_i, cmp_sel_reg};
      default:    rd_data = 32'h0000_0000;
    endcase
  end

  // bus answer registers
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req;
      dat_o <= req ? rd_data : 32'h0000_0000;
    end
  end

  // software controls
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      ctrl_a_reg  <= CTRL_RST;
      ctrl_b_reg  <= CTRL_RST;
      irq_en_reg  <= FLAG_RST;
      cmp_sel_reg <= 1'b0;
    end else begin
      if (wr_ctrl_a)
        ctrl_a_reg <= dat_i[7:0];
      if (wr_ctrl_b)
        ctrl_b_reg <= dat_i[7:0];
      if (wr_irq_en)
        irq_en_reg <= dat_i[1:0];
      if (wr_cmp)
        cmp_sel_reg <= dat_i[CMP_SEL_BIT];
    end
  end

  // shared latch: high writes fill it, low reads load it
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i)
      temp_reg <= 8'h00;
    else if (wr_cnt_hi || wr_cap_hi)
      temp_reg <= dat_i[7:0];
    else if (rd_cnt_lo)
      temp_reg <= counter_value_reg[15:8];
    else if (rd_cap_lo)
      temp_reg <= capture_value_reg[15:8];
  end

  // counter, direction, prescaler and edge history
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      counter_value_reg <= CNT_RST;
      dir_reg           <= dir_up;
      presc_reg         <= '0;
      ext_prev_reg      <= 1'b0;
      cap_prev_reg      <= 1'b0;
      bottom_o          <= 1'b1;
    end else begin
      counter_value_reg <= counter_value_next;
      dir_reg           <= tick ? dir_next : dir_reg;
      presc_reg         <= presc_reg + 1'b1;
      ext_prev_reg      <= ext_level;
      cap_prev_reg      <= cap_level;
      bottom_o          <= counter_value_next == BOTTOM_VAL;
    end
  end

  // capture overwrites unread values; bus writes only as top
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i)
      capture_value_reg <= CNT_RST;
    else if (cap_trig)
      capture_value_reg <= counter_value_reg;
    else if (wr_cap_lo && cap_is_top)
      capture_value_reg <= {temp_reg, dat_i[7:0]};
  end

  // flags and requests; requests come from flops
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      flag_reg       <= FLAG_RST;
      overflow_irq_o <= 1'b0;
      capture_irq_o  <= 1'b0;
    end else begin
      flag_reg       <= flag_next;
      overflow_irq_o <= flag_next[OVF_BIT] && irq_en_reg[OVF_BIT];
      capture_irq_o  <= flag_next[CAP_BIT] && irq_en_reg[CAP_BIT];
    end
  end

  // trigger path: switching source may itself capture
  capture_conditioner u_cap_cond (
    .mclk_i      (mclk_i),
    .reset_n_i   (reset_n_i),
    .raw_i       (cap_src),
    .filter_en_i (ctrl_b_reg.filter_en),
    .level_o     (cap_level)
  );

  // external count pin, same sampling without filter
  capture_conditioner u_ext_cond (
    .mclk_i      (mclk_i),
    .reset_n_i   (reset_n_i),
    .raw_i       (external_count_pin_i),
    .filter_en_i (1'b0),
    .level_o     (ext_level)
  );

  // checks
  property p_stop;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (cs == CS_STOP && !wr_cnt_lo) |=> $stable(counter_value_reg);
  endproperty
  a_stop: assert property (p_stop)
    else $error("counter moved while stopped");

  property p_write_prio;
    @(posedge mclk_i) disable iff (!reset_n_i)
      wr_cnt_lo |=> counter_value_reg == {$past(temp_reg),
                                          $past(dat_i[7:0])};
  endproperty
  a_write_prio: assert property (p_write_prio)
    else $error("counter write lost");

  property p_low_read;
    @(posedge mclk_i) disable iff (!reset_n_i)
      rd_cnt_lo |=> temp_reg == $past(counter_value_reg[15:8]);
  endproperty
  a_low_read: assert property (p_low_read)
    else $error("latch not loaded on low read");

  property p_latch_hold;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (wr_cnt_lo || wr_cap_lo) |=> $stable(temp_reg);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latch lost on low write");

  property p_capture;
    @(posedge mclk_i) disable iff (!reset_n_i)
      cap_trig |=> capture_value_reg == $past(counter_value_reg)
                   && flag_reg[CAP_BIT];
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture value or flag wrong");

  property p_w1c;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (wr_flag && dat_i[CAP_BIT] && !cap_trig) |=> !flag_reg[CAP_BIT];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("capture flag not cleared by one");

  property p_w0_keep;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (wr_flag && !dat_i[CAP_BIT] && flag_reg[CAP_BIT] &&
       !capture_irq_ack_i) |=> flag_reg[CAP_BIT];
  endproperty
  a_w0_keep: assert property (p_w0_keep)
    else $error("capture flag cleared by zero");

  property p_cap_lock;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (wr_cap_lo && !cap_is_top && !cap_trig) |=>
        $stable(capture_value_reg);
  endproperty
  a_cap_lock: assert property (p_cap_lock)
    else $error("capture register written outside top mode");

  property p_top_no_cap;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (cap_is_top && !wr_cap_lo) |=> $stable(capture_value_reg);
  endproperty
  a_top_no_cap: assert property (p_top_no_cap)
    else $error("capture fired in capture-top mode");

  property p_bottom;
    @(posedge mclk_i) disable iff (!reset_n_i)
      bottom_o == (counter_value_reg == BOTTOM_VAL);
  endproperty
  a_bottom: assert property (p_bottom)
    else $error("bottom does not match counter");

  c_capture: cover property (@(posedge mclk_i) cap_trig);
  c_overflow: cover property (@(posedge mclk_i) ovf_event);
  c_down: cover property (@(posedge mclk_i) dir_reg == dir_down);
  c_cap_irq: cover property (@(posedge mclk_i) capture_irq_o);
endmodule

/* File: timer16_pkg.sv */
// shared constants and types of the 16-bit timer with input capture
package timer16_pkg;
  // register byte addresses on the bus
  localparam logic [7:0] CTRL_A_ADR      = 8'h00;
  localparam logic [7:0] CTRL_B_ADR      = 8'h04;
  localparam logic [7:0] CNT_LO_ADR      = 8'h08;
  localparam logic [7:0] CNT_HI_ADR      = 8'h0C;
  localparam logic [7:0] CAP_LO_ADR      = 8'h10;
  localparam logic [7:0] CAP_HI_ADR      = 8'h14;
  localparam logic [7:0] FLAG_ADR        = 8'h18;
  localparam logic [7:0] IRQ_EN_ADR      = 8'h1C;
  localparam logic [7:0] CMP_CS_ADR      = 8'h20;
  // flag, enable and comparator bit positions
  localparam int OVF_BIT                 = 0;
  localparam int CAP_BIT                 = 1;
  localparam int CMP_SEL_BIT             = 0;
  localparam int CMP_RES_BIT             = 1;
  // reset values
  localparam logic [7:0] CTRL_RST        = 8'h00;
  localparam logic [15:0] CNT_RST        = 16'h0000;
  localparam logic [1:0] FLAG_RST        = 2'h0;
  // count limits
  localparam logic [15:0] BOTTOM_VAL     = 16'h0000;
  localparam logic [15:0] MAX_VAL        = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT       = 16'h00FF;
  localparam logic [15:0] TOP_9BIT       = 16'h01FF;
  localparam logic [15:0] TOP_10BIT      = 16'h03FF;
  // clock sources
  localparam logic [2:0] CS_STOP         = 3'h0;
  localparam logic [2:0] CS_DIV1         = 3'h1;
  localparam logic [2:0] CS_DIV8         = 3'h2;
  localparam logic [2:0] CS_DIV64        = 3'h3;
  localparam logic [2:0] CS_DIV256       = 3'h4;
  localparam logic [2:0] CS_DIV1024      = 3'h5;
  localparam logic [2:0] CS_EXT_FALL     = 3'h6;
  localparam int PRESC_W                 = 10;
  // noise filter sample count
  localparam int FILT_SAMPLES            = 4;
  // control register b layout
  typedef struct packed {
    logic       filter_en;
    logic       edge_rise;
    logic       unused;
    logic [1:0] wgm_hi;
    logic [2:0] clock_source_select;
  } ctrl_b_type;
  typedef enum logic {dir_up, dir_down} count_dir_type;
endpackage

/* File: capture_conditioner.sv */
// pin synchroniser with optional four-sample noise filter
`timescale 1ns/100ps
module capture_conditioner
  import timer16_pkg::*;
(
  input  wire logic mclk_i,      // system clock
  input  wire logic reset_n_i,   // sync reset, active low
  input  wire logic raw_i,       // asynchronous input
  input  wire logic filter_en_i, // enable noise filter
  output logic      level_o      // conditioned level
);
  logic [2:0]              sync_reg;
  logic                    stable_reg;
  logic [FILT_SAMPLES-1:0] hist_reg;
  logic                    all_high;
  logic                    all_low;
  logic                    level_next;

  // three flops; only the second and third are compared
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      sync_reg   <= 3'h0;
      stable_reg <= 1'b0;
      hist_reg   <= '0;
      level_o    <= 1'b0;
    end else begin
      sync_reg   <= {sync_reg[1:0], raw_i};
      if (sync_reg[1] == sync_reg[2])
        stable_reg <= sync_reg[2];
      hist_reg   <= {hist_reg[FILT_SAMPLES-2:0], stable_reg};
      level_o    <= level_next;
    end
  end

  // filter moves only on four equal samples
  assign all_high   = &hist_reg;
  assign all_low    = ~|hist_reg;
  assign level_next = !filter_en_i ? stable_reg :
                      all_high ? 1'b1 : all_low ? 1'b0 : level_o;

  property p_filter_agree;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (filter_en_i && level_next != level_o) |-> (all_high || all_low);
  endproperty
  a_filter_agree: assert property (p_filter_agree)
    else $error("filter output moved without four equal samples");
endmodule

/* File: bus_master_model.sv */
// processor-side wishbone master issuing classic single byte cycles
`timescale 1ns/100ps
module bus_master_model (
  input  wire logic        mclk_i,  // system clock
  input  wire logic        ack_i,   // slave acknowledge
  output logic             cyc_o,   // bus cycle
  output logic             stb_o,   // strobe
  output logic             we_o,    // write enable
  output logic [7:0]       adr_o,   // byte address
  output logic [3:0]       sel_o,   // byte selects
  output logic [31:0]      dat_o,   // write data
  output logic             stuck_o  // an answer never came
);
  // idle bus at time zero
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0;
    stuck_o = 1'b0;
  end

  // request held until ack is sampled; released address and data are
  // inverted so the slave cannot lean on stale values
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d);
    int n;
    @(posedge mclk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= 4'h1;
    dat_o <= {24'h0, d};
    for (n = 0; n < 50; n++) begin
      @(posedge mclk_i);
      if (ack_i === 1'b1) break;
    end
    if (n == 50) stuck_o = 1'b1;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    adr_o <= ~a;
    dat_o <= {24'h0, ~d};
  endtask

  // sixteen-bit write: high byte into the shared latch, then low byte
  task automatic wr16(input logic [7:0] lo, input logic [15:0] v);
    xfer(1'b1, lo + 8'h04, v[15:8]);
    xfer(1'b1, lo, v[7:0]);
  endtask
endmodule

/* File: tb.sv */
// self-checking bench for the 16-bit timer with input capture
`timescale 1ns/100ps
module tb;
  import timer16_pkg::*;
  logic        mclk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        cyc_i, stb_i, we_i, ack_o, stuck;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o;
  logic        ovf_irq, cap_irq, bottom_o;
  logic        cap_pin = 1'b0, cmp_res = 1'b0, ext_pin = 1'b0;
  logic        ovf_ack = 1'b0, cap_ack = 1'b0;
  logic [31:0] exp_q[$];
  int          bad_count = 0, cmp_count = 0, lat0, lat1;
  logic [15:0] v;

  always #5 mclk_i = ~mclk_i;

  timer16_capture dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .capture_pin_i(cap_pin), .comparator_result_i(cmp_res),
    .external_count_pin_i(ext_pin), .overflow_irq_ack_i(ovf_ack),
    .capture_irq_ack_i(cap_ack), .overflow_irq_o(ovf_irq),
    .capture_irq_o(cap_irq), .bottom_o(bottom_o));
  bus_master_model bus (.mclk_i(mclk_i), .ack_i(ack_o), .cyc_o(cyc_i),
    .stb_o(stb_i), .we_o(we_i), .adr_o(adr_i), .sel_o(sel_i),
    .dat_o(dat_i), .stuck_o(stuck));

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic hung();
    bad_count++;
    final_report();
  endtask

  // read answers are matched in order against the noted expectations
  always @(posedge mclk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0) begin
      if (exp_q.size() == 0) chk("unexpected read", 32'h1, 32'h0);
      else chk("read data", exp_q.pop_front(), dat_o);
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus.xfer(1'b1, a, d);
    if (stuck) hung();
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    bus.xfer(1'b0, a, 8'h00);
    if (stuck) hung();
  endtask
  // low byte first so the high read returns the latched byte
  task automatic rd16(input logic [7:0] lo, input logic [15:0] e);
    rd(lo, e[7:0]);
    rd(lo + 8'h04, e[15:8]);
  endtask
  // pulses on the external count pin, slow enough for the synchroniser
  task automatic ticks(input int n);
    repeat (n) begin
      repeat (3) @(posedge mclk_i);
      ext_pin <= 1'b1;
      repeat (3) @(posedge mclk_i);
      ext_pin <= 1'b0;
    end
    repeat (8) @(posedge mclk_i);
  endtask
  // cycles from a pin change until the capture request shows
  task automatic lat(output int n);
    for (n = 0; n < 60; n++) begin
      @(posedge mclk_i);
      if (cap_irq === 1'b1) break;
    end
    if (n == 60) hung();
  endtask
  // run mode {h,a} on the external rising clock from s for n ticks
  task automatic run(input logic [1:0] a, input logic [1:0] h,
                     input logic [15:0] s, input int n,
                     input logic [15:0] e);
    ctrl_b_type cb;
    cb = '{1'b0, 1'b1, 1'b0, h, 3'h7};
    wr(CTRL_A_ADR, {6'h00, a});
    wr(CTRL_B_ADR, cb);
    bus.wr16(CNT_LO_ADR, s);
    ticks(n);
    wr(CTRL_B_ADR, 8'h00);
    rd16(CNT_LO_ADR, e);
  endtask
  // one-cycle service pulse: cap selects the capture line, else overflow
  task automatic pulse_ack(input logic cap);
    if (cap)
      cap_ack <= 1'b1;
    else
      ovf_ack <= 1'b1;
    @(posedge mclk_i);
    cap_ack <= 1'b0;
    ovf_ack <= 1'b0;
    @(posedge mclk_i);
  endtask

  initial begin
    void'($urandom(14));
    repeat (5) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    rd16(CNT_LO_ADR, CNT_RST);
    chk("bottom", 32'h1, {31'h0, bottom_o});
    rd(8'h3C, 8'h00);
    $display("test reset and map done");
    wr(IRQ_EN_ADR, 8'h03);
    run(2'h0, 2'h0, 16'hFFFE, 3, 16'h0001);
    rd(FLAG_ADR, 8'h01);
    chk("overflow irq", 32'h1, {31'h0, ovf_irq});
    pulse_ack(1'b0);
    rd(FLAG_ADR, 8'h00);
    run(2'h1, 2'h1, 16'h00FE, 3, 16'h0001);
    run(2'h1, 2'h0, 16'h00FE, 3, 16'h00FD);
    ticks(2);
    rd16(CNT_LO_ADR, 16'h00FD);
    wr(CTRL_A_ADR, 8'h00);
    wr(CTRL_B_ADR, {5'h00, CS_EXT_FALL});
    ticks(2);
    wr(CTRL_B_ADR, 8'h00);
    rd16(CNT_LO_ADR, 16'h00FF);
    // one tick per clock from the take of the start write to the stop
    wr(CTRL_B_ADR, {5'h00, CS_DIV1});
    wr(CTRL_B_ADR, 8'h00);
    rd16(CNT_LO_ADR, 16'h0102);
    $display("test counting done");
    v = 16'($urandom);
    wr(CTRL_B_ADR, 8'h40);
    bus.wr16(CNT_LO_ADR, v);
    wr(FLAG_ADR, 8'h03);
    cap_pin <= 1'b1;
    lat(lat0);
    rd(FLAG_ADR, 8'h02);
    rd16(CAP_LO_ADR, v);
    wr(FLAG_ADR, 8'h00);
    rd(FLAG_ADR, 8'h02);
    wr(FLAG_ADR, 8'h02);
    rd(FLAG_ADR, 8'h00);
    v = ~v;
    bus.wr16(CNT_LO_ADR, v);
    wr(CTRL_B_ADR, 8'h00);
    wr(FLAG_ADR, 8'h02);
    cap_pin <= 1'b0;
    lat(lat1);
    pulse_ack(1'b1);
    rd(FLAG_ADR, 8'h00);
    rd16(CAP_LO_ADR, v);
    $display("test capture done");
    wr(CTRL_B_ADR, 8'hC0);
    cap_pin <= 1'b1;
    repeat (2) @(posedge mclk_i);
    cap_pin <= 1'b0;
    repeat (20) @(posedge mclk_i);
    rd(FLAG_ADR, 8'h00);
    cap_pin <= 1'b1;
    lat(lat1);
    chk("filter latency", lat0 + 4, lat1);
    $display("test filter done");
    wr(CTRL_B_ADR, 8'h40);
    wr(CMP_CS_ADR, 8'h01);
    wr(FLAG_ADR, 8'h02);
    rd(CMP_CS_ADR, 8'h01);
    cmp_res <= 1'b1;
    lat(lat1);
    rd(CMP_CS_ADR, 8'h03);
    wr(FLAG_ADR, 8'h02);
    cap_pin <= 1'b0;
    repeat (6) @(posedge mclk_i);
    cap_pin <= 1'b1;
    repeat (20) @(posedge mclk_i);
    rd(FLAG_ADR, 8'h00);
    $display("test comparator source done");
    wr(CMP_CS_ADR, 8'h00);
    bus.wr16(CAP_LO_ADR, 16'h1234);
    rd16(CAP_LO_ADR, v);
    wr(CTRL_B_ADR, 8'h58);
    wr(CAP_HI_ADR, 8'hAB);
    wr(CAP_LO_ADR, 8'h02);
    wr(CNT_LO_ADR, 8'h01);
    rd16(CAP_LO_ADR, 16'hAB02);
    rd16(CNT_LO_ADR, 16'hAB01);
    wr(FLAG_ADR, 8'h03);
    cap_pin <= 1'b0;
    repeat (6) @(posedge mclk_i);
    cap_pin <= 1'b1;
    repeat (20) @(posedge mclk_i);
    rd(FLAG_ADR, 8'h00);
    $display("test capture top mode done");
    // reset again in mid-run; counter, control b and flags must return to zero
    reset_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    rd16(CNT_LO_ADR, CNT_RST);
    rd(CTRL_B_ADR, CTRL_RST);
    rd(FLAG_ADR, 8'h00);
    chk("bottom after reset", 32'h1, {31'h0, bottom_o});
    $display("test mid-run reset done");
    final_report();
  end
endmodule
